// *** pmu_power_enable_reset_irq.sv ***
`timescale 1ns/100ps
`include "pmu_cfg.svh"
module pmu_power_enable_reset_irq
  import pmu_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int unsigned RELEASE_CYCLES  = `RELEASE_CYCLES,
  parameter bit          ADJUSTABLE      = 1'b0,
  parameter logic [7:0]  BOTH_EDGE_MASK  = 8'h0F
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Analog status, asynchronous
  input  wire logic        undervoltage_lockout,
  input  wire logic        ldo_over_temp,
  input  wire logic        ldo_power_good,
  input  wire logic        threshold_above,
  input  wire logic        adapter_source_valid,
  input  wire logic        battery_present,
  // User pins, asynchronous
  input  wire logic        power_button_n,
  input  wire logic        buck_hold_in,
  input  wire logic        regulator_hold_in,
  // Interrupt sources, asynchronous
  input  wire logic [7:0]  irq_source,
  // Register access from the serial slave
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Regulator control
  output logic             buck_converter_en,
  output logic             linear_regulator_en,
  output logic             thermal_sense_en,
  output logic             shutdown,
  output logic             adapter_power_good,
  // Pin configuration
  output logic [3:0]       pin_direction,
  output logic [3:0]       pin_level,
  // Open-drain outputs, oe high pulls low
  output logic             reset_out,
  output logic             reset_oe,
  output logic             irq_out,
  output logic             irq_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  uv_s, ot_s, pg_s, th_s, ad_s, bat_s, pb_s, bh_s, rh_s;
    logic [15:0] irq_s;        // Two stages of eight sources
    logic        pb_db;        // Debounced button, low = pressed
    logic [31:0] db_cnt;       // Debounce counter
    logic        powered_once; // First power-up seen on battery
    logic        buck_on;
    logic        ldo_on;
    logic [7:0]  src_prev;     // Previous source levels
    sup_state_t  sup;
    logic [31:0] rel_cnt;      // Release delay counter
    regs_t       regs;
    logic [7:0]  rdata;
    logic        rst_oe;
    logic        int_oe;
    logic        apg;
    logic        tsen;
    logic        sd;
    logic        hot_off;      // Thermal trip held until requests drop
  } st_t;

  st_t st_r, st_nxt;

  // Synchronised levels, second stage only
  logic uv, ot, pg, th, ad, bat, pb, bh, rh;
  logic [7:0] src;
  assign uv  = st_r.uv_s[1];
  assign ot  = st_r.ot_s[1];
  assign pg  = st_r.pg_s[1];
  assign th  = st_r.th_s[1];
  assign ad  = st_r.ad_s[1];
  assign bat = st_r.bat_s[1];
  assign pb  = st_r.pb_s[1];
  assign bh  = st_r.bh_s[1];
  assign rh  = st_r.rh_s[1];
  assign src = st_r.irq_s[15:8];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       want_buck, want_ldo, rst_cond, reg_dflt;
    logic [7:0] edge_hit, set_v;
    want_buck = 1'b0;
    want_ldo  = 1'b0;
    rst_cond  = 1'b0;
    reg_dflt  = 1'b0;
    edge_hit  = 8'h00;
    set_v     = 8'h00;
    st_nxt = st_r;
    // Two-flop synchronisers
    st_nxt.uv_s  = {st_r.uv_s[0], undervoltage_lockout};
    st_nxt.ot_s  = {st_r.ot_s[0], ldo_over_temp};
    st_nxt.pg_s  = {st_r.pg_s[0], ldo_power_good};
    st_nxt.th_s  = {st_r.th_s[0], threshold_above};
    st_nxt.ad_s  = {st_r.ad_s[0], adapter_source_valid};
    st_nxt.bat_s = {st_r.bat_s[0], battery_present};
    st_nxt.pb_s  = {st_r.pb_s[0], power_button_n};
    st_nxt.bh_s  = {st_r.bh_s[0], buck_hold_in};
    st_nxt.rh_s  = {st_r.rh_s[0], regulator_hold_in};
    st_nxt.irq_s = {st_r.irq_s[7:0], irq_source};

    // Adapter flag mirrors a valid charging source
    st_nxt.apg = ad;

    // Debounce: restart on any change before expiry
    if (pb == st_r.pb_db) begin
      st_nxt.db_cnt = '0;
    end else if (st_r.db_cnt >= DEBOUNCE_CYCLES - 1) begin
      st_nxt.pb_db  = pb;
      st_nxt.db_cnt = '0;
    end else begin
      st_nxt.db_cnt = st_r.db_cnt + 32'd1;
    end

    // Hold pins act as enables only after a first power-up on battery
    if (!bat) begin
      st_nxt.powered_once = 1'b0;
    end else if (!st_r.pb_db || st_r.apg) begin
      st_nxt.powered_once = 1'b1;
    end

    want_buck = !st_r.pb_db || st_r.apg
      || (st_r.buck_on && st_r.regs.buck_setting_reg[`HOLD_BIT_POS])
      || (bh && (st_r.buck_on || st_r.powered_once))
      || st_r.regs.control_reg_one[`GLOBAL_HOLD_POS];
    want_ldo  = !st_r.pb_db || st_r.apg
      || (st_r.ldo_on && st_r.regs.regulator_control_reg[`HOLD_BIT_POS])
      || (rh && (st_r.ldo_on || st_r.powered_once))
      || st_r.regs.control_reg_one[`GLOBAL_HOLD_POS];

    // Trip is held: the sensor goes dark once the regulator drops
    if (st_r.tsen && ot) begin
      st_nxt.hot_off = 1'b1;
    end else if (!want_buck && !want_ldo) begin
      st_nxt.hot_off = 1'b0;
    end
    // Lockout and over-temperature override every enable
    if (uv || (st_r.tsen && ot) || st_r.hot_off) begin
      st_nxt.buck_on = 1'b0;
      st_nxt.ldo_on  = 1'b0;
    end else begin
      st_nxt.buck_on = want_buck;
      st_nxt.ldo_on  = want_ldo;
    end
    st_nxt.tsen = st_nxt.ldo_on;
    st_nxt.sd   = !st_nxt.buck_on && !st_nxt.ldo_on;

    // Supervisor condition per variant
    if (ADJUSTABLE) begin
      rst_cond = !th;
    end else begin
      rst_cond = !pg || !st_r.ldo_on;
    end

    // Release only after the condition stays absent for the delay
    unique case (st_r.sup)
      SUP_HOLD: begin
        st_nxt.rel_cnt = '0;
        if (!rst_cond) begin
          st_nxt.sup = SUP_COUNT;
        end
      end
      SUP_COUNT: begin
        if (rst_cond) begin
          st_nxt.sup     = SUP_HOLD;
          st_nxt.rel_cnt = '0;
        end else if (st_r.rel_cnt >= RELEASE_CYCLES - 1) begin
          st_nxt.sup = SUP_RELEASE;
        end else begin
          st_nxt.rel_cnt = st_r.rel_cnt + 32'd1;
        end
      end
      SUP_RELEASE: begin
        if (rst_cond) begin
          st_nxt.sup = SUP_HOLD;
        end
      end
      default: st_nxt.sup = SUP_HOLD;
    endcase
    st_nxt.rst_oe = (st_nxt.sup != SUP_RELEASE);

    // Interrupt edge detection, set only when unmasked
    for (int i = 0; i < 8; i++) begin
      edge_hit[i] = BOTH_EDGE_MASK[i] ? (src[i] ^ st_r.src_prev[i])
                                      : (src[i] & ~st_r.src_prev[i]);
    end
    set_v = edge_hit & ~st_r.regs.irq_mask_reg_a;
    st_nxt.src_prev = src;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `CTRL_ONE_ADDR:  st_nxt.regs.control_reg_one       = reg_wdata;
        `BUCK_SET_ADDR:  st_nxt.regs.buck_setting_reg      = reg_wdata;
        `REG_CTRL_ADDR:  st_nxt.regs.regulator_control_reg = reg_wdata;
        `PIN_DIR_ADDR:   st_nxt.regs.pin_direction_reg     = reg_wdata[3:0];
        `PIN_LEVEL_ADDR: st_nxt.regs.pin_level_reg         = reg_wdata[3:0];
        `MASK_ADDR:      st_nxt.regs.irq_mask_reg_a        = reg_wdata;
        default: st_nxt.rdata = st_nxt.rdata;
      endcase
    end

    // Register reads; flag read clears, new events win
    st_nxt.rdata = `UNMAPPED_READ;
    if (reg_rd) begin
      unique case (reg_addr)
        `CTRL_ONE_ADDR:  st_nxt.rdata = st_r.regs.control_reg_one;
        `BUCK_SET_ADDR:  st_nxt.rdata = st_r.regs.buck_setting_reg;
        `REG_CTRL_ADDR:  st_nxt.rdata = st_r.regs.regulator_control_reg;
        `PIN_DIR_ADDR:   st_nxt.rdata = {4'h0, st_r.regs.pin_direction_reg};
        `PIN_LEVEL_ADDR: st_nxt.rdata = {4'h0, st_r.regs.pin_level_reg};
        `MASK_ADDR:      st_nxt.rdata = st_r.regs.irq_mask_reg_a;
        `FLAG_ADDR: begin
          st_nxt.rdata = st_r.regs.irq_flag_reg_a;
          st_nxt.regs.irq_flag_reg_a = '0;
        end
        default: st_nxt.rdata = `UNMAPPED_READ;
      endcase
    end
    st_nxt.regs.irq_flag_reg_a = st_nxt.regs.irq_flag_reg_a | set_v;

    // Defaults on lockout or while reset pin is pulled low
    reg_dflt = uv || st_r.rst_oe;
    if (reg_dflt) begin
      st_nxt.regs.control_reg_one       = `CTRL_ONE_RST;
      st_nxt.regs.buck_setting_reg      = `BUCK_SET_RST;
      st_nxt.regs.regulator_control_reg = `REG_CTRL_RST;
      st_nxt.regs.pin_direction_reg     = `PIN_DIR_RST;
      st_nxt.regs.pin_level_reg         = `PIN_LEVEL_RST;
      st_nxt.regs.irq_mask_reg_a        = `MASK_RST;
      st_nxt.regs.irq_flag_reg_a        = `FLAG_RST;
    end
    st_nxt.int_oe = |st_nxt.regs.irq_flag_reg_a;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r                              <= '0;
      st_r.pb_s                         <= 2'b11;
      st_r.pb_db                        <= 1'b1;
      st_r.sup                          <= SUP_HOLD;
      st_r.rst_oe                       <= 1'b1;
      st_r.sd                           <= 1'b1;
      st_r.regs.pin_direction_reg       <= `PIN_DIR_RST;
      st_r.regs.irq_mask_reg_a          <= `MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs from flops; reset_out and irq_out tied low
  // ****************************************************************
  assign reg_rdata           = st_r.rdata;
  assign buck_converter_en   = st_r.buck_on;
  assign linear_regulator_en = st_r.ldo_on;
  assign thermal_sense_en    = st_r.tsen;
  assign shutdown            = st_r.sd;
  assign adapter_power_good  = st_r.apg;
  assign pin_direction       = st_r.regs.pin_direction_reg;
  assign pin_level           = st_r.regs.pin_level_reg;
  assign reset_out           = 1'b0;
  assign reset_oe            = st_r.rst_oe;
  assign irq_out             = 1'b0;
  assign irq_oe              = st_r.int_oe;

endmodule : pmu_power_enable_reset_irq

// *** pmu_cfg.svh ***
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      10
`define DEBOUNCE_MS        50
`define RELEASE_MS         100
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_MS * 1000000) / `CLK_PERIOD_NS)
`define RELEASE_CYCLES     ((`RELEASE_MS * 1000000) / `CLK_PERIOD_NS)
// ****************************************************************
// Register offsets
// ****************************************************************
`define CTRL_ONE_ADDR      8'h10
`define BUCK_SET_ADDR      8'h11
`define REG_CTRL_ADDR      8'h12
`define PIN_DIR_ADDR       8'h13
`define PIN_LEVEL_ADDR     8'h14
`define MASK_ADDR          8'h15
`define FLAG_ADDR          8'h16
// ****************************************************************
// Field positions
// ****************************************************************
`define HOLD_BIT_POS       7
`define GLOBAL_HOLD_POS    5
`define PIN_COUNT          4
// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_ONE_RST       8'h00
`define BUCK_SET_RST       8'h00
`define REG_CTRL_RST       8'h00
`define PIN_DIR_RST        4'hC
`define PIN_LEVEL_RST      4'h0
`define MASK_RST           8'hFF
`define FLAG_RST           8'h00
`define UNMAPPED_READ      8'h00
`endif

// *** pmu_pkg.sv ***
package pmu_pkg;
  // Supervisor states
  typedef enum logic [1:0] {
    SUP_HOLD    = 2'b00,
    SUP_COUNT   = 2'b01,
    SUP_RELEASE = 2'b10
  } sup_state_t;

  // Register file image
  typedef struct packed {
    logic [7:0] control_reg_one;
    logic [7:0] buck_setting_reg;
    logic [7:0] regulator_control_reg;
    logic [3:0] pin_direction_reg;
    logic [3:0] pin_level_reg;
    logic [7:0] irq_mask_reg_a;
    logic [7:0] irq_flag_reg_a;
  } regs_t;

  // Regulator enables and shutdown view
  typedef struct packed {
    logic buck_en;
    logic ldo_en;
    logic thermal_sense_en;
    logic shutdown;
  } power_t;
endpackage : pmu_pkg

// *** pmu_power_enable_reset_irq_assertions.sv ***
`timescale 1ns/100ps
// ****
// Power, reset and pin checks
// ****
module pmu_power_enable_reset_irq_assertions
  import pmu_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = 20,
  parameter int unsigned RELEASE_CYCLES  = 30
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Watched inputs
  input wire logic       undervoltage_lockout,
  input wire logic       ldo_over_temp,
  input wire logic       ldo_power_good,
  input wire logic       adapter_source_valid,
  input wire logic       power_button_n,
  input wire logic       buck_hold_in,
  input wire logic       regulator_hold_in,
  // Watched outputs
  input wire logic       buck_converter_en,
  input wire logic       linear_regulator_en,
  input wire logic       thermal_sense_en,
  input wire logic       shutdown,
  input wire logic [3:0] pin_direction,
  input wire logic [3:0] pin_level,
  input wire logic       reset_out,
  input wire logic       reset_oe,
  input wire logic       irq_out,
  input wire logic       irq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] btn_cnt_r;  // Button low run, saturating
  logic [15:0] good_cnt_r; // Regulator good run, saturating
  // Run counters; too long for a repetition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      btn_cnt_r  <= 16'h0000;
      good_cnt_r <= 16'h0000;
    end else begin
      btn_cnt_r  <= power_button_n ? 16'h0000 : btn_cnt_r + {15'h0000, ~&btn_cnt_r};
      good_cnt_r <= (linear_regulator_en && ldo_power_good) ?
                    good_cnt_r + {15'h0000, ~&good_cnt_r} : 16'h0000;
    end
  end
  chk_lockout_off: assert property (
    undervoltage_lockout [*4] |-> !buck_converter_en && !linear_regulator_en)
    else $error("regulator on in lockout");
  chk_sense_follows: assert property (thermal_sense_en == linear_regulator_en)
    else $error("thermal sense mismatch");
  chk_hot_both_off: assert property (
    $fell(linear_regulator_en) && ldo_over_temp |-> !buck_converter_en)
    else $error("buck left on in thermal shutdown");
  chk_shutdown_state: assert property (
    shutdown == (!buck_converter_en && !linear_regulator_en))
    else $error("shutdown flag mismatch");
  chk_reset_when_off: assert property (!linear_regulator_en [*4] |-> reset_oe)
    else $error("reset released with regulator off");
  chk_release_early: assert property ($fell(reset_oe) |-> good_cnt_r >= RELEASE_CYCLES)
    else $error("reset released too early");
  chk_release_late: assert property (
    good_cnt_r == RELEASE_CYCLES + 8 |-> !reset_oe)
    else $error("reset not released");
  chk_debounce_wait: assert property (
    $rose(buck_converter_en) && !adapter_source_valid && !buck_hold_in &&
    !regulator_hold_in |-> btn_cnt_r >= DEBOUNCE_CYCLES)
    else $error("button accepted before debounce");
  chk_button_on: assert property (
    btn_cnt_r == DEBOUNCE_CYCLES + 4 && !undervoltage_lockout && !ldo_over_temp
    |-> buck_converter_en && linear_regulator_en) else $error("button did not enable");
  chk_pin_default: assert property (
    reset_oe && $past(reset_oe) |-> pin_direction == 4'hC && pin_level == 4'h0)
    else $error("pin registers not at default");
  chk_open_drain: assert property (reset_out == 1'b0 && irq_out == 1'b0)
    else $error("open drain drives high");
  cov_release: cover property ($fell(reset_oe));
  cov_irq: cover property ($rose(irq_oe));
  cov_hot: cover property ($fell(linear_regulator_en) && ldo_over_temp);
endmodule : pmu_power_enable_reset_irq_assertions

bind pmu_power_enable_reset_irq pmu_power_enable_reset_irq_assertions #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) chk_u (.*);

// *** pmu_analog_model.sv ***
`timescale 1ns/100ps
// ****
// Regulator and pull-up model
// ****
module pmu_analog_model (
  // Clock
  input wire logic  clk,
  // Regulator enable and power good
  input wire logic  linear_regulator_en,
  output logic      ldo_power_good,
  // Open-drain pins
  input wire logic  reset_oe,
  input wire logic  irq_oe,
  output wire logic reset_pin,
  output wire logic irq_pin
);
  logic [2:0] ramp_r = 3'h0; // Output ramp after enable
  // Good only after a ramp; drops at once on disable
  always_ff @(posedge clk) ramp_r <= linear_regulator_en ? {ramp_r[1:0], 1'b1} : 3'h0;
  assign ldo_power_good = ramp_r[2];
  // Pull-ups win while nobody pulls low
  assign reset_pin = reset_oe ? 1'b0 : 1'b1;
  assign irq_pin   = irq_oe ? 1'b0 : 1'b1;
endmodule : pmu_analog_model

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  import pmu_pkg::*;
  localparam int unsigned DB = 20; // Short debounce
  localparam int unsigned RL = 30; // Short release delay
  // ****
  // Signals, all inputs defined from time zero
  // ****
  logic clk = 1'b0, arst_n = 1'b0, threshold_above = 1'b0, battery_present = 1'b1;
  logic undervoltage_lockout = 1'b0, ldo_over_temp = 1'b0, adapter_source_valid = 1'b0;
  logic power_button_n = 1'b1, buck_hold_in = 1'b0, regulator_hold_in = 1'b0;
  logic [7:0] irq_source = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ldo_power_good, adapter_power_good;
  logic buck_converter_en, linear_regulator_en, thermal_sense_en, shutdown;
  logic reset_out, reset_oe, irq_out, irq_oe;
  logic [3:0] pin_direction, pin_level;
  wire reset_pin, irq_pin;
  int errors = 0;
  int num_checks = 0;
  pmu_power_enable_reset_irq #(.DEBOUNCE_CYCLES(DB), .RELEASE_CYCLES(RL)) dut_u (.*);
  pmu_analog_model model_u (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Enables packed as buck, regulator, sense, shutdown
  task automatic pw(input logic [3:0] e);
    chk({4'h0, buck_converter_en, linear_regulator_en, thermal_sense_en, shutdown}, {4'h0, e});
  endtask : pw
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr
  // Data lands on the edge that samples the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    cyc(1);
  endtask : rd
  // Press and hold until reset lets go
  task automatic press();
    power_button_n = 1'b0;
    cyc(DB + 5);
    pw(4'hE);
    cyc(RL + 15);
    chk({7'h00, reset_pin}, 8'h01);
  endtask : press
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    cyc(12);
    arst_n = 1'b1;
    pw(4'h1);
    chk({4'h0, pin_direction}, 8'h0C);
    chk({7'h00, reset_pin}, 8'h00);
    rd(8'h15, 8'hFF);
    rd(8'h3C, 8'h00);
    // Short bounces must be ignored, and a bounce restarts the count
    power_button_n = 1'b0;
    cyc(DB - 5);
    pw(4'h1);
    power_button_n = 1'b1;
    cyc(2);
    power_button_n = 1'b0;
    cyc(DB - 5);
    pw(4'h1);
    power_button_n = 1'b1;
    cyc(DB + 8);
    pw(4'h1);
    $display("test defaults and debounce done");
    press();
    wr(8'h13, 8'h03);
    rd(8'h13, 8'h03);
    wr(8'h14, 8'h05);
    rd(8'h14, 8'h05);
    chk({4'h0, pin_direction}, 8'h03);
    chk({4'h0, pin_level}, 8'h05);
    wr(8'h10, 8'h20);
    rd(8'h10, 8'h20);
    power_button_n = 1'b1;
    cyc(DB + 8);
    pw(4'hE);
    wr(8'h10, 8'h00);
    cyc(4);
    pw(4'h1);
    chk({7'h00, reset_pin}, 8'h00);
    rd(8'h13, 8'h0C);
    chk({4'h0, pin_level}, 8'h00);
    press();
    wr(8'h12, 8'h80);
    power_button_n = 1'b1;
    cyc(DB + 8);
    pw(4'h6);
    wr(8'h12, 8'h00);
    cyc(4);
    pw(4'h1);
    press();
    buck_hold_in = 1'b1;
    power_button_n = 1'b1;
    cyc(DB + 8);
    pw(4'h8);
    regulator_hold_in = 1'b1;
    cyc(5);
    pw(4'hE);
    buck_hold_in = 1'b0;
    regulator_hold_in = 1'b0;
    cyc(5);
    pw(4'h1);
    // After battery loss a hold pin alone must not power up
    battery_present = 1'b0;
    cyc(5);
    battery_present = 1'b1;
    regulator_hold_in = 1'b1;
    cyc(8);
    pw(4'h1);
    regulator_hold_in = 1'b0;
    $display("test hold sources done");
    adapter_source_valid = 1'b1;
    cyc(5);
    pw(4'hE);
    chk({7'h00, adapter_power_good}, 8'h01);
    cyc(RL + 15);
    wr(8'h15, 8'hFE);
    irq_source[4] = 1'b1;
    cyc(4);
    chk({7'h00, irq_pin}, 8'h01);
    irq_source[0] = 1'b1;
    cyc(4);
    chk({7'h00, irq_pin}, 8'h00);
    rd(8'h16, 8'h01);
    cyc(1);
    chk({7'h00, irq_pin}, 8'h01);
    irq_source[0] = 1'b0;
    cyc(4);
    rd(8'h16, 8'h01);
    wr(8'h15, 8'hEF);
    irq_source[4] = 1'b0;
    cyc(4);
    rd(8'h16, 8'h00);
    irq_source[4] = 1'b1;
    cyc(4);
    rd(8'h16, 8'h10);
    $display("test interrupts done");
    ldo_over_temp = 1'b1;
    for (int i = 0; i < 8 && linear_regulator_en; i++) cyc(1);
    pw(4'h1);
    cyc(3);
    pw(4'h1);
    adapter_source_valid = 1'b0;
    cyc(5);
    ldo_over_temp = 1'b0;
    cyc(5);
    adapter_source_valid = 1'b1;
    cyc(5);
    pw(4'hE);
    undervoltage_lockout = 1'b1;
    cyc(5);
    pw(4'h1);
    cyc(20);
    pw(4'h1);
    rd(8'h15, 8'hFF);
    $display("test thermal and lockout done");
    results();
  end
endmodule : tb
